//--- rtl/modem_status_indicator_control.sv
// Purpose: Lamp patterns, mode control and port selection of the radio modem
// Assumes: Firmware posts radio events and strength samples over APB
// Notes: Board inputs pass two flops; lamps come from flip-flops
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module modem_status_indicator_control #(
    parameter int step_count = indicator_pkg::step_cycles,
    parameter int silence_count = indicator_pkg::silence_cycles
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Board inputs
    input wire logic config_button_n,
    input wire logic power_down_input_n,
    input wire logic request_to_send_n,
    // Lamps
    output var indicator_pkg::lamps_type lamps,
    // Port and power control
    output logic clear_to_send_n,
    output logic rs232_data_enable,
    output logic rs485_data_enable,
    output logic diag_at_disable,
    output logic [17:0] rs232_baud,
    output logic [17:0] diag_baud,
    output logic shutdown
);

    // =====================================================================
    // Input synchronisers
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 3'h7;
            sync_b <= 3'h7;
        end else begin
            sync_a <= {config_button_n, power_down_input_n, request_to_send_n};
            sync_b <= sync_a;
        end
    end
    wire logic button_held = !sync_b[2];
    wire logic power_down = !sync_b[1];
    wire logic rts_active = !sync_b[0];

    // =====================================================================
    // APB decode
    wire logic access = psel && penable;
    wire logic wr = access && pwrite;
    wire logic hit_ctrl = paddr == indicator_pkg::ctrl_addr;
    wire logic hit_rssi = paddr == indicator_pkg::rssi_addr;
    wire logic hit_event = paddr == indicator_pkg::event_addr;
    wire logic hit_status = paddr == indicator_pkg::status_addr;
    wire logic hit_thresh = paddr == indicator_pkg::thresh_addr;
    wire logic mapped = hit_ctrl || hit_rssi || hit_event || hit_status || hit_thresh;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // =====================================================================
    // Control state
    indicator_pkg::mode_type mode;
    indicator_pkg::role_type role;
    logic synced;
    logic port_rs485;
    logic core_ok;
    logic [17:0] data_baud;
    logic boot_done;
    logic [7:0] thr1, thr2, thr3;
    logic rx_event, tx_event, hop_second, from_master;
    wire logic ctrl_wr = wr && hit_ctrl;
    wire logic [17:0] wr_baud = pwdata[indicator_pkg::baud_lsb +: 18];
    wire logic baud_ok = wr_baud >= indicator_pkg::baud_min && wr_baud <= indicator_pkg::baud_max;
    // Each threshold is lifted to the one below it, so the order always holds
    wire logic [7:0] wr_thr2 = (pwdata[15:8] < pwdata[7:0]) ? pwdata[7:0] : pwdata[15:8];
    wire logic [7:0] wr_thr3 = (pwdata[23:16] < wr_thr2) ? wr_thr2 : pwdata[23:16];

    // Synchroniser flops reset to idle, so the strap waits for a real pin sample
    logic [1:0] boot_pipe;
    wire logic strap_take = boot_pipe[1] && !boot_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            boot_pipe <= 2'h0;
        else
            boot_pipe <= {boot_pipe[0], 1'b1};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= indicator_pkg::mode_command;
            role <= indicator_pkg::role_master;
            synced <= 1'b0;
            port_rs485 <= 1'b0;
            core_ok <= 1'b1;
            data_baud <= indicator_pkg::baud_config;
            boot_done <= 1'b0;
        end else begin
            boot_done <= boot_pipe[1];
            if (strap_take) begin
                // Strap caught once the synchroniser holds a pin sample
                if (button_held) begin
                    mode <= indicator_pkg::mode_command;
                    port_rs485 <= 1'b0;
                    data_baud <= indicator_pkg::baud_config;
                end else begin
                    mode <= indicator_pkg::mode_data;
                end
            end else if (boot_done && ctrl_wr) begin
                if (pwdata[indicator_pkg::go_online_bit])
                    mode <= indicator_pkg::mode_data;
                else if (pwdata[indicator_pkg::go_command_bit])
                    mode <= indicator_pkg::mode_command;
                role <= indicator_pkg::role_type'(pwdata[indicator_pkg::role_lsb +: 2]);
                synced <= pwdata[indicator_pkg::synced_bit];
                port_rs485 <= pwdata[indicator_pkg::port_sel_bit];
                core_ok <= pwdata[indicator_pkg::core_ok_bit];
                if (baud_ok)
                    data_baud <= wr_baud;
            end
        end
    end

    // Radio events are levels posted by firmware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_event <= 1'b0;
            tx_event <= 1'b0;
            hop_second <= 1'b0;
            from_master <= 1'b0;
            thr1 <= indicator_pkg::thresh1_reset;
            thr2 <= indicator_pkg::thresh2_reset;
            thr3 <= indicator_pkg::thresh3_reset;
        end else begin
            if (wr && hit_event) begin
                rx_event <= pwdata[indicator_pkg::ev_rx_valid_bit];
                tx_event <= pwdata[indicator_pkg::ev_tx_bit];
                hop_second <= pwdata[indicator_pkg::ev_hop_second_bit];
                from_master <= pwdata[indicator_pkg::ev_from_master_bit];
            end
            // Lifted on write so thresholds stay monotonic
            if (wr && hit_thresh) begin
                thr1 <= pwdata[7:0];
                thr2 <= wr_thr2;
                thr3 <= wr_thr3;
            end
        end
    end

    // =====================================================================
    // Strength average over last four good packets
    logic [7:0] samples [4];
    wire logic sample_wr = wr && hit_rssi;
    wire logic slave_sample = sample_wr && !from_master;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++)
                samples[i] <= 8'h00;
        end else if (sample_wr) begin
            samples[0] <= pwdata[7:0];
            for (int i = 1; i < 4; i++)
                samples[i] <= samples[i - 1];
        end
    end
    wire logic [9:0] sum = 10'(samples[0]) + 10'(samples[1]) + 10'(samples[2]) + 10'(samples[3]);
    wire logic [7:0] strength = sum[9:2];
    wire logic [1:0] level = (strength >= thr3) ? 2'h3 : (strength >= thr2) ? 2'h2 : 2'h1;

    // Slave silence timer for the repeater fallback
    logic [31:0] silence;
    wire logic slaves_silent = silence >= 32'(silence_count);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            silence <= 32'h0;
        else if (slave_sample)
            silence <= 32'h0;
        else if (!slaves_silent)
            silence <= silence + 32'h1;
    end

    // =====================================================================
    // Cycling step timer
    logic [31:0] step_timer;
    logic [1:0] cycle_pos;
    wire logic step_end = step_timer >= 32'(step_count - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_timer <= 32'h0;
            cycle_pos <= 2'h0;
        end else if (step_end) begin
            step_timer <= 32'h0;
            cycle_pos <= (cycle_pos == 2'h2) ? 2'h0 : cycle_pos + 2'h1;
        end else begin
            step_timer <= step_timer + 32'h1;
        end
    end

    // =====================================================================
    // Lamp pattern
    wire logic is_data = mode == indicator_pkg::mode_data;
    wire logic is_master = role == indicator_pkg::role_master;
    wire logic is_repeater = role == indicator_pkg::role_repeater;
    wire logic acquiring = is_data && !synced;
    wire logic [2:0] cycle_lamps = 3'h1 << cycle_pos;
    // Repeater shows strength capped at two; master packets blank it until slaves went quiet
    wire logic use_level = !is_repeater || slaves_silent || !from_master;
    wire logic [1:0] rep_level = (level == 2'h3) ? 2'h2 : level;
    wire logic [1:0] shown = is_repeater ? rep_level : level;
    wire logic [2:0] fill = (shown == 2'h3) ? 3'h7 : (shown == 2'h2) ? 3'h3 : 3'h1;
    indicator_pkg::lamps_type next_lamps;
    always_comb begin
        next_lamps = '0;
        next_lamps.system_lamp = core_ok && !power_down;
        if (!is_data || power_down) begin
            next_lamps.receive_sync_lamp = 1'b0;
        end else if (acquiring) begin
            next_lamps.transmit_lamp = is_master;
            {next_lamps.strength_lamp_three, next_lamps.strength_lamp_two,
                next_lamps.strength_lamp_one} = cycle_lamps;
        end else begin
            if (is_master) begin
                next_lamps.transmit_lamp = 1'b1;
                next_lamps.receive_sync_lamp = rx_event;
            end else if (is_repeater) begin
                next_lamps.receive_sync_lamp = !hop_second;
                next_lamps.transmit_lamp = hop_second;
            end else begin
                next_lamps.receive_sync_lamp = 1'b1;
                next_lamps.transmit_lamp = tx_event;
            end
            if (use_level)
                {next_lamps.strength_lamp_three, next_lamps.strength_lamp_two,
                    next_lamps.strength_lamp_one} = fill;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamps <= '0;
            clear_to_send_n <= 1'b1;
            rs232_data_enable <= 1'b0;
            rs485_data_enable <= 1'b0;
            shutdown <= 1'b0;
        end else begin
            lamps <= next_lamps;
            clear_to_send_n <= !(rts_active && is_data && !power_down);
            rs232_data_enable <= is_data && !port_rs485 && !power_down;
            rs485_data_enable <= is_data && port_rs485 && !power_down;
            shutdown <= power_down;
        end
    end

    assign rs232_baud = is_data ? data_baud : indicator_pkg::baud_config;
    assign diag_baud = indicator_pkg::baud_diag;
    assign diag_at_disable = 1'b1;

    // =====================================================================
    // Read mux
    wire logic [31:0] ctrl_rd = {6'h0, data_baud, 1'b0, core_ok, port_rs485, synced, role,
        2'h0};
    wire logic [31:0] status_rd = {20'h0, mode, shutdown, slaves_silent, level, 1'b0,
        lamps};
    assign prdata = hit_ctrl ? ctrl_rd :
        hit_rssi ? {24'h0, strength} :
        hit_event ? {28'h0, from_master, hop_second, tx_event, rx_event} :
        hit_status ? status_rd :
        hit_thresh ? {8'h0, thr3, thr2, thr1} : 32'h0;

    // =====================================================================
    // Checks
    command_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(is_data) |-> !lamps.transmit_lamp && !lamps.receive_sync_lamp
        && lamps[2:0] == 3'h0) else $error("lamps lit in command mode");
    master_tx_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(is_data && synced && is_master && !power_down) |-> lamps.transmit_lamp)
        else $error("master transmit lamp off");
    acquire_dark_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(acquiring && !is_master) |-> !lamps.transmit_lamp && !lamps.receive_sync_lamp)
        else $error("acquiring lamps lit");
    slave_rx_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(is_data && synced && role == indicator_pkg::role_slave && !power_down)
        |-> lamps.receive_sync_lamp) else $error("slave sync lamp off");
    fill_left_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(is_data && synced) && lamps.strength_lamp_two |-> lamps.strength_lamp_one)
        else $error("strength lamps not filled from left");
    one_port_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(rs232_data_enable && rs485_data_enable)) else $error("both ports on");
    shutdown_a: assert property (@(posedge pclk) disable iff (!presetn)
        power_down |=> shutdown) else $error("shutdown missed");
    online_a: assert property (@(posedge pclk) disable iff (!presetn)
        boot_done && ctrl_wr && pwdata[indicator_pkg::go_online_bit] |=> is_data)
        else $error("online command ignored");
    hop_split_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(is_data && synced && is_repeater && !power_down) |-> lamps.transmit_lamp
        == $past(hop_second) && lamps.receive_sync_lamp == !$past(hop_second))
        else $error("repeater hop lamps wrong");
    strap_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        strap_take && button_held |=> !is_data) else $error("strap mode wrong");
    thr_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        thr1 <= thr2 && thr2 <= thr3) else $error("thresholds out of order");

endmodule // modem_status_indicator_control

`default_nettype wire

//--- include/indicator_pkg.sv
// Purpose: Constants and types for the modem status indicator and mode control block
// Assumes: pclk at 100 MHz; software drives mode, role and radio events over APB
// Notes: Functional notes follow below
// Functional notes
// - System lamp lit when powered and healthy; command mode shows only it.
// - Receive/sync lamp shows network sync and valid packets received.
// - Transmit lamp shows air transmission; synced slave lights it per packet.
// - Data-mode master holds transmit on; receive lamp only on valid packets.
// - Data-mode master lights one to three strength lamps by strength.
// - Master fast sync or repeater/slave acquisition cycles strength lamps, 300 ms.
// - Acquiring repeater/slave: both lamps off; fast-sync master: transmit on only.
// - Synced repeater: receive lamp first hop portion, transmit lamp second.
// - Synced repeater: one or two lamps by slaves, master strength after 2 s silence.
// - Synced slave holds receive lamp on, one to three strength lamps.
// - Strength averages last four good packets; lamps fill from the left.
// - Button held at power-up boots configuration mode, RS-232 at 9600 baud.
// - Grounded power-down input shuts the device down.
// - RS-232 port carries data 300-230400 baud in data mode, configuration otherwise.
// - Data passes over only one port, RS-232 or RS-422/485.
// - Diagnostic port runs at 115.2 kbaud, firmware upgrade, no AT commands.
// - Clear-to-send driven active low; request-to-send is active-low input.
// - Online command in command mode enters data mode.

package indicator_pkg;

    // =====================================================================
    // Register map (byte addresses)
    localparam logic [7:0] ctrl_addr = 8'h00;
    localparam logic [7:0] rssi_addr = 8'h04;
    localparam logic [7:0] event_addr = 8'h08;
    localparam logic [7:0] status_addr = 8'h0C;
    localparam logic [7:0] thresh_addr = 8'h10;

    // =====================================================================
    // Control fields
    localparam int go_online_bit = 0;
    localparam int go_command_bit = 1;
    localparam int role_lsb = 2;
    localparam int synced_bit = 4;
    localparam int port_sel_bit = 5;
    localparam int core_ok_bit = 6;
    localparam int baud_lsb = 8;

    // Event fields
    localparam int ev_rx_valid_bit = 0;
    localparam int ev_tx_bit = 1;
    localparam int ev_hop_second_bit = 2;
    localparam int ev_from_master_bit = 3;

    // Reset values of thresholds: monotonic ascending
    localparam logic [7:0] thresh1_reset = 8'h40;
    localparam logic [7:0] thresh2_reset = 8'h80;
    localparam logic [7:0] thresh3_reset = 8'hC0;

    // Baud rates
    localparam logic [17:0] baud_config = 18'h02580;
    localparam logic [17:0] baud_min = 18'h0012C;
    localparam logic [17:0] baud_max = 18'h38400;
    localparam logic [17:0] baud_diag = 18'h1C200;

    // =====================================================================
    // Timing
    localparam int clk_mhz = 100;
    localparam int step_ms = 300;
    localparam int silence_ms = 2000;
    localparam int step_cycles = step_ms * 1000 * clk_mhz;
    localparam int silence_cycles = silence_ms * 1000 * clk_mhz;

    typedef enum logic [1:0] {
        role_master,
        role_repeater,
        role_slave,
        role_spare
    } role_type;

    typedef enum logic {
        mode_command,
        mode_data
    } mode_type;

    typedef struct packed {
        logic system_lamp;
        logic receive_sync_lamp;
        logic transmit_lamp;
        logic strength_lamp_three;
        logic strength_lamp_two;
        logic strength_lamp_one;
    } lamps_type;

endpackage

//--- bench/board_model.sv
// Purpose: Board side of the indicator block: button, power-down pin, terminal handshake
// Assumes: Bench requests are levels; pins change only after a clock edge
// Notes: Pins idle high, as the board pull-ups leave them
`timescale 1ns/1ps
`default_nettype none

module board_model (
    // Clock
    input wire logic pclk,
    // Bench requests
    input wire logic hold_button,
    input wire logic ground_shutdown,
    input wire logic terminal_wants_send,
    // Board pins
    output logic config_button_n,
    output logic power_down_input_n,
    output logic request_to_send_n
);
    // =====================================================================
    // Pin drivers
    logic btn_q = 1'b0;
    logic power_down_input_q = 1'b0;
    logic rts_q = 1'b0;
    always @(posedge pclk) begin
        btn_q <= hold_button;
        power_down_input_q <= ground_shutdown;
        rts_q <= terminal_wants_send;
    end
    assign config_button_n = !btn_q;
    assign power_down_input_n = !power_down_input_q;
    assign request_to_send_n = !rts_q;
endmodule // board_model

`default_nettype wire

//--- bench/tb_modem_status_indicator_control.sv
// Purpose: Self-checking bench for the status indicator and mode control block
// Assumes: Short step and silence counts so cycling and silence show in a few cycles
// Notes: Registers are reached through one APB task; each scenario is one task
`timescale 1ns/1ps
`default_nettype none

module tb_modem_status_indicator_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic hold_button, ground_shutdown, wants_send;
    logic config_button_n, power_down_input_n, request_to_send_n;
    indicator_pkg::lamps_type lamps;
    logic clear_to_send_n, rs232_data_enable, rs485_data_enable, diag_at_disable, shutdown;
    logic [17:0] rs232_baud, diag_baud;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checked = 0;

    modem_status_indicator_control #(.step_count(10), .silence_count(50)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .config_button_n(config_button_n), .power_down_input_n(power_down_input_n),
        .request_to_send_n(request_to_send_n), .lamps(lamps), .clear_to_send_n(clear_to_send_n),
        .rs232_data_enable(rs232_data_enable), .rs485_data_enable(rs485_data_enable),
        .diag_at_disable(diag_at_disable), .rs232_baud(rs232_baud), .diag_baud(diag_baud),
        .shutdown(shutdown));

    board_model board (
        .pclk(pclk), .hold_button(hold_button), .ground_shutdown(ground_shutdown),
        .terminal_wants_send(wants_send), .config_button_n(config_button_n),
        .power_down_input_n(power_down_input_n), .request_to_send_n(request_to_send_n));

    // =====================================================================
    // Shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Control word keeps core status good so the system lamp stays lit
    function automatic logic [31:0] ctrl_w(logic [1:0] go, logic [1:0] role, logic sync,
                                           logic port, logic [17:0] baud);
        return {6'h00, baud, 1'b0, 1'b1, port, sync, role, go};
    endfunction

    task automatic set_ctrl(input logic [1:0] go, input logic [1:0] role, input logic sync);
        apb(1'b1, indicator_pkg::ctrl_addr, ctrl_w(go, role, sync, 1'b0,
            indicator_pkg::baud_config));
    endtask

    task automatic samples(input logic [7:0] v);
        repeat (4) apb(1'b1, indicator_pkg::rssi_addr, {24'h000000, v});
    endtask

    task automatic wait_lamps(input logic [5:0] exp, input int lim, input string nm);
        int n;
        n = 0;
        while (lamps !== exp && n < lim) begin
            @(posedge pclk);
            n++;
        end
        check(nm, {26'h0, lamps}, {26'h0, exp});
        if (lamps !== exp)
            end_sim();
    endtask

    task automatic do_reset(input logic btn);
        hold_button <= btn;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        hold_button <= 1'b0;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_regs();
        apb(1'b0, indicator_pkg::ctrl_addr, 32'h0);
        check("ctrl reset", rd, 32'h00258040);
        apb(1'b0, indicator_pkg::thresh_addr, 32'h0);
        check("thresh reset", rd, 32'h00C08040);
        apb(1'b1, indicator_pkg::thresh_addr, 32'h00102080);
        apb(1'b0, indicator_pkg::thresh_addr, 32'h0);
        check("thresh sorted", rd, 32'h00808080);
        apb(1'b1, indicator_pkg::thresh_addr, 32'h00C08040);
        apb(1'b0, indicator_pkg::status_addr, 32'h0);
        check("mode after plain boot", {31'h0, rd[11]}, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", {err, rd[30:0]}, 32'h80000000);
        $display("regs done");
    endtask

    task automatic t_command();
        do_reset(1'b1);
        wait_lamps(6'h20, 12, "command lamps");
        check("config baud", {14'h0, rs232_baud}, 32'h02580);
        check("ports off", {rs232_data_enable, rs485_data_enable}, 32'h0);
        set_ctrl(2'b01, indicator_pkg::role_master, 1'b1);
        apb(1'b0, indicator_pkg::status_addr, 32'h0);
        check("online", {31'h0, rd[11]}, 32'h1);
        $display("command done");
    endtask

    task automatic t_master();
        samples(8'hFF);
        apb(1'b0, indicator_pkg::rssi_addr, 32'h0);
        check("average", rd, 32'h000000FF);
        wait_lamps(6'h2F, 12, "master strong");
        apb(1'b1, indicator_pkg::event_addr, 32'h1);
        wait_lamps(6'h3F, 12, "master receive");
        apb(1'b1, indicator_pkg::event_addr, 32'h0);
        samples(8'h50);
        wait_lamps(6'h29, 12, "master weak");
        samples(8'h90);
        wait_lamps(6'h2B, 12, "master medium");
        $display("master done");
    endtask

    task automatic t_cycle(input logic [1:0] role, input logic [2:0] top, input string nm);
        logic ok;
        logic [2:0] mask;
        ok = 1'b1;
        mask = 3'b000;
        set_ctrl(2'b00, role, 1'b0);
        repeat (3) @(posedge pclk);
        repeat (40) begin
            @(posedge pclk);
            mask = mask | lamps[2:0];
            ok = ok && lamps[5:3] === top && $onehot(lamps[2:0]);
        end
        check(nm, {28'h0, ok, mask}, 32'hF);
        $display("%s done", nm);
    endtask

    task automatic t_slave();
        set_ctrl(2'b00, indicator_pkg::role_slave, 1'b1);
        samples(8'hFF);
        wait_lamps(6'h37, 12, "slave synced");
        apb(1'b1, indicator_pkg::event_addr, 32'h2);
        wait_lamps(6'h3F, 12, "slave transmit");
        apb(1'b1, indicator_pkg::event_addr, 32'h0);
        wait_lamps(6'h37, 12, "slave idle");
        $display("slave done");
    endtask

    task automatic t_repeater();
        set_ctrl(2'b00, indicator_pkg::role_repeater, 1'b1);
        samples(8'hFF);
        wait_lamps(6'h33, 12, "repeater first hop");
        apb(1'b1, indicator_pkg::event_addr, 32'h4);
        wait_lamps(6'h2B, 12, "repeater second hop");
        apb(1'b1, indicator_pkg::event_addr, 32'h8);
        samples(8'h50);
        wait_lamps(6'h31, 80, "repeater master source");
        apb(1'b0, indicator_pkg::status_addr, 32'h0);
        check("slaves silent", {31'h0, rd[9]}, 32'h1);
        apb(1'b1, indicator_pkg::event_addr, 32'h0);
        $display("repeater done");
    endtask

    task automatic t_ports();
        apb(1'b1, indicator_pkg::ctrl_addr, ctrl_w(2'b00, 2'b00, 1'b1, 1'b0, 18'h38400));
        wants_send <= 1'b1;
        repeat (6) @(posedge pclk);
        check("cts", {31'h0, clear_to_send_n}, 32'h0);
        check("rs232 only", {rs232_data_enable, rs485_data_enable}, 32'h2);
        check("data baud", {14'h0, rs232_baud}, 32'h38400);
        check("diag", {diag_at_disable, diag_baud}, {13'h0, 1'b1, 18'h1C200});
        apb(1'b1, indicator_pkg::ctrl_addr, ctrl_w(2'b00, 2'b00, 1'b1, 1'b1, 18'h00100));
        repeat (3) @(posedge pclk);
        check("low baud refused", {14'h0, rs232_baud}, 32'h38400);
        check("rs485 only", {rs232_data_enable, rs485_data_enable}, 32'h1);
        set_ctrl(2'b10, indicator_pkg::role_master, 1'b1);
        wait_lamps(6'h20, 12, "back to command");
        check("command ports", {rs485_data_enable, clear_to_send_n}, 32'h1);
        check("command baud", {14'h0, rs232_baud}, 32'h02580);
        $display("ports done");
    endtask

    task automatic t_power_down();
        ground_shutdown <= 1'b1;
        repeat (6) @(posedge pclk);
        check("shutdown", {shutdown, lamps.system_lamp}, 32'h2);
        $display("power down done");
    endtask

    // =====================================================================
    // Clock and main sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hold_button = 1'b0;
        ground_shutdown = 1'b0;
        wants_send = 1'b0;
        do_reset(1'b0);
        t_regs();
        t_command();
        t_master();
        t_cycle(indicator_pkg::role_master, 3'b101, "fast sync");
        t_cycle(indicator_pkg::role_slave, 3'b100, "slave acquire");
        t_cycle(indicator_pkg::role_repeater, 3'b100, "repeater acquire");
        t_slave();
        t_repeater();
        t_ports();
        t_power_down();
        end_sim();
    end
endmodule // tb_modem_status_indicator_control

`default_nettype wire
